// file: include/frm_pkg.sv
// Purpose: Shared constants, types and carriers of the FPGA image reload manager
// Assumes: 100 MHz mclk, four flash image slots, 32-bit configuration words
// Notes:   Host-facing controls are plain ports; no software register bus
package frm_pkg;
    localparam int DATA_W       = 32;
    localparam int FADDR_W      = 22;
    localparam int IMG_W        = 2;
    localparam int IMG_CNT      = 4;
    localparam int IMG_WORDS_W  = 20;
    localparam int CFG_ADDR_W   = 2;

    // Timing
    localparam int CLK_MHZ      = 100;
    localparam int PROG_LOW_NS  = 500;
    localparam int PROG_LOW_CYC = (PROG_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int DONE_TMO_MS  = 2000;
    localparam int DONE_TMO_CYC = DONE_TMO_MS * CLK_MHZ * 1000;
    localparam int STRAP_SETTLE = 4;

    // Host configuration space word addresses
    localparam logic [CFG_ADDR_W-1:0] CFG_ID   = 2'h0;
    localparam logic [CFG_ADDR_W-1:0] CFG_CMD  = 2'h1;
    localparam logic [CFG_ADDR_W-1:0] CFG_STAT = 2'h2;
    localparam logic [DATA_W-1:0]     CMD_RST  = 32'h00000000;

    // Status word fields
    localparam int STAT_CONF_BIT = 0;
    localparam int STAT_FAIL_BIT = 1;
    localparam int STAT_JTAG_BIT = 2;
    localparam int STAT_IMG_LSB  = 4;
    localparam int STAT_SEL_LSB  = 8;
    localparam int STAT_BOOT_LSB = 12;

    typedef enum logic [2:0] {
        S_BOOT, S_PROG, S_FLASH, S_STREAM, S_WAIT, S_RUN, S_FAIL, S_JTAG
    } frm_state_e;

    typedef enum logic [1:0] {
        SRC_FLASH, SRC_STREAM
    } frm_src_e;

    typedef enum logic [1:0] {
        RD_IDLE, RD_REQ, RD_WAIT
    } frm_rd_e;

    // Configuration port toward the FPGA
    typedef struct packed {
        logic              prog_n;
        logic              wr;
        logic [DATA_W-1:0] data;
    } frm_fcfg_s;

    // Flash word write
    typedef struct packed {
        logic               wr;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } frm_fwr_s;
endpackage

// file: tb/fpga_image_reload_manager_bench.sv
// Purpose: Self-checking bench of the reload manager
// Assumes: Inputs driven at the falling edge, short done timeout
// Notes:   The boot flash load is cut short by JTAG and the reload by the end of the test, since a slot is 2^20 words
`timescale 1ns/1ps
module fpga_image_reload_manager_bench;
    localparam logic [31:0] ID = 32'h0C3E1AB5;
    logic mclk, rstn, cfg_rd, cfg_wr, host_sel_valid, host_reload, host_strm_start, host_strm_valid;
    logic host_strm_last, host_fw_valid, jtag_fw_valid, jtag_cfg_active, usr_req, load_ok, no_fw;
    logic cfg_rvalid, host_strm_ready, host_fw_ready, jtag_fw_ready, flash_rd_req, flash_rd_valid;
    logic fpga_done, user_rst_n, usr_grant;
    logic [1:0]  cfg_addr, host_sel_img, boot_sw;
    logic [21:0] host_fw_addr, jtag_fw_addr, flash_rd_addr;
    logic [31:0] cfg_wdata, host_strm_data, host_fw_data, jtag_fw_data, flash_rd_data, cfg_rdata, d, cmdv, w;
    frm_pkg::frm_fwr_s  flash_wr;
    frm_pkg::frm_fcfg_s fpga_cfg;
    logic [31:0] exp_q[$];
    int          error_cnt = 0, checks_done = 0, i;

    frm_reload_manager #(.DONE_TMO_CYC(200), .VENDOR_ID(16'h1AB5), .DEVICE_ID(16'h0C3E)) u_dut
    (.mclk, .rstn, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rvalid, .cfg_rdata, .host_sel_valid,
     .host_sel_img, .host_reload, .host_strm_start, .host_strm_valid, .host_strm_last, .host_strm_data,
     .host_strm_ready, .host_fw_valid, .host_fw_addr, .host_fw_data, .host_fw_ready, .jtag_fw_valid,
     .jtag_fw_addr, .jtag_fw_data, .jtag_fw_ready, .flash_rd_req, .flash_rd_addr, .flash_rd_valid,
     .flash_rd_data, .flash_wr, .boot_sw, .jtag_cfg_active, .fpga_done, .fpga_cfg, .user_rst_n,
     .usr_req, .usr_grant);
    frm_board_model u_board
    (.mclk, .rd_req(flash_rd_req), .rd_addr(flash_rd_addr), .rd_valid(flash_rd_valid),
     .rd_data(flash_rd_data), .prog_n(fpga_cfg.prog_n), .load_ok, .done(fpga_done));

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk) s = 1'b1;
        @(negedge mclk) s = 1'b0;
    endtask
    task automatic cfg_read(logic [1:0] a, output logic [31:0] r);
        @(negedge mclk) {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge mclk) cfg_rd = 1'b0;
        chk("cfg_rvalid", 1, cfg_rvalid);
        r = cfg_rdata;
    endtask
    function automatic logic [31:0] fword(logic [1:0] s, int k);
        return {10'h0, s, k[19:0]} ^ 32'h5A5A0000;
    endfunction
    task automatic wait_run();
        // Held over two falling edges so the board model cannot miss it
        @(negedge mclk) load_ok = 1'b1;
        repeat (2) @(negedge mclk);
        load_ok = 1'b0;
        for (i = 0; i < 50 && user_rst_n !== 1'b1; i++) @(negedge mclk);
        chk("user_rst_n", 1, user_rst_n);
        chk("usr_grant", 1, usr_grant);
    endtask
    task automatic strm(int n);
        pulse(host_strm_start);
        no_fw = 1'b1;
        for (i = 0; i < 100 && host_strm_ready !== 1'b1; i++) @(negedge mclk);
        for (int k = 0; k < n; k++)
        begin
            w = $urandom;
            exp_q.push_back(w);
            {host_strm_valid, host_strm_data, host_strm_last} = {1'b1, w, k == n - 1};
            @(negedge mclk);
        end
        host_strm_valid = 1'b0;
        @(negedge mclk);
        chk("strm_left", 0, exp_q.size());
        wait_run();
        no_fw = 1'b0;
        cfg_read(frm_pkg::CFG_ID, d);
        chk("cfg_id", ID, d);
        cfg_read(frm_pkg::CFG_CMD, d);
        chk("cfg_cmd", cmdv, d);
    endtask

    always @(negedge mclk)
    begin
        if (fpga_cfg.wr === 1'b1 && exp_q.size() > 0)
            chk("fpga_word", exp_q.pop_front(), fpga_cfg.data);
        if (no_fw)
            chk("flash_wr_wr", 0, flash_wr.wr);
    end
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        {rstn, cfg_rd, cfg_wr, host_sel_valid, host_reload, host_strm_start, host_strm_valid} = '0;
        {host_strm_last, host_fw_valid, jtag_fw_valid, jtag_cfg_active, load_ok, no_fw} = '0;
        {cfg_addr, host_sel_img, cfg_wdata, host_strm_data, host_fw_addr, host_fw_data} = '0;
        {jtag_fw_addr, jtag_fw_data} = '0;
        {boot_sw, usr_req} = {2'h2, 1'b1};
        w = $urandom(32'hAE0B);
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        cfg_read(frm_pkg::CFG_ID, d);
        chk("cfg_id", ID, d);
        cmdv = $urandom;
        @(negedge mclk) {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, frm_pkg::CFG_CMD, cmdv};
        @(negedge mclk) cfg_wr = 1'b0;
        for (int k = 0; k < 4; k++) exp_q.push_back(fword(2'h2, k));
        for (i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge mclk);
        chk("boot_left", 0, exp_q.size());
        chk("fw_ready", 0, {jtag_fw_ready, host_fw_ready});
        chk("usr_grant", 0, usr_grant);
        cfg_read(frm_pkg::CFG_STAT, d);
        chk("boot_img", 2, d[13:12]);
        jtag_cfg_active = 1'b1;
        repeat (6) @(negedge mclk);
        chk("prog_n", 1, fpga_cfg.prog_n);
        cfg_read(frm_pkg::CFG_STAT, d);
        chk("jtag_bit", 1, d[2]);
        jtag_cfg_active = 1'b0;
        repeat (6) @(negedge mclk);
        wait_run();
        {host_fw_valid, host_fw_addr, host_fw_data} = {1'b1, 22'($urandom), 32'($urandom)};
        {jtag_fw_valid, jtag_fw_addr, jtag_fw_data} = {1'b1, 22'($urandom), 32'($urandom)};
        #1 chk("host_fw_ready", 0, host_fw_ready);
        chk("jtag_fw_ready", 1, jtag_fw_ready);
        @(negedge mclk) jtag_fw_valid = 1'b0;
        chk("jtag_fw", {1'b1, jtag_fw_addr, jtag_fw_data}, {flash_wr.wr, flash_wr.addr, flash_wr.data});
        @(negedge mclk) host_fw_valid = 1'b0;
        chk("host_fw", {1'b1, host_fw_addr, host_fw_data}, {flash_wr.wr, flash_wr.addr, flash_wr.data});
        strm(5);
        strm(3);
        host_sel_img = 2'h1;
        pulse(host_sel_valid);
        for (int k = 0; k < 3; k++) exp_q.push_back(fword(2'h1, k));
        pulse(host_reload);
        chk("usr_grant", 0, usr_grant);
        for (i = 0; i < 100 && fpga_cfg.prog_n === 1'b0; i++) @(negedge mclk);
        chk("prog_low", frm_pkg::PROG_LOW_CYC, i);
        for (i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge mclk);
        chk("reload_left", 0, exp_q.size());
        cfg_read(frm_pkg::CFG_STAT, d);
        chk("sel_img", 1, d[9:8]);
        stop_test();
    end
endmodule

// file: tb/frm_board_model.sv
// Purpose: Flash and FPGA done pin as seen from the reload manager
// Assumes: Reads answered 1 to 3 cycles after the request
// Notes:   Idle read data toggles so a stale word never matches
`timescale 1ns/1ps
module frm_board_model
(
    input  wire logic                        mclk,
    input  wire logic                        rd_req,
    input  wire logic [frm_pkg::FADDR_W-1:0] rd_addr,
    output logic                             rd_valid,
    output logic      [frm_pkg::DATA_W-1:0]  rd_data,
    input  wire logic                        prog_n,
    input  wire logic                        load_ok,
    output logic                             done
);
    int                          dly = 0;
    logic [frm_pkg::FADDR_W-1:0] a;
    logic                        hit;
    initial
    begin
        rd_valid = 1'b0;
        rd_data = 32'h0;
        done = 1'b0;
    end
    always @(negedge mclk)
    begin
        // Answer when the countdown from the last request expires
        hit = (rd_req !== 1'b1) && (dly == 1);
        rd_valid <= hit;
        rd_data <= hit ? ({10'h0, a} ^ 32'h5A5A0000) : ~rd_data;
        if (prog_n === 1'b0)
            done <= 1'b0;
        else if (load_ok)
            done <= 1'b1;
        if (rd_req === 1'b1)
        begin
            a = rd_addr;
            dly = 1 + $urandom_range(2);
        end
        else if (dly > 0)
            dly--;
    end
endmodule

// file: verilog/frm_flash_reader.sv
// Purpose: Streams one whole flash image slot into the FPGA configuration port
// Assumes: One outstanding flash read at a time; read data returns with rd_valid
// Notes:   Abort drops the transfer at once, used when JTAG takes the FPGA
`timescale 1ns/1ps
module frm_flash_reader
(
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic                        start,
    input  wire logic                        abort,
    input  wire logic [frm_pkg::IMG_W-1:0]   slot,
    output logic                             flash_rd_req,
    output logic      [frm_pkg::FADDR_W-1:0] flash_rd_addr,
    input  wire logic                        flash_rd_valid,
    input  wire logic [frm_pkg::DATA_W-1:0]  flash_rd_data,
    output logic                             word_wr,
    output logic      [frm_pkg::DATA_W-1:0]  word_data,
    output logic                             done
);
    frm_pkg::frm_rd_e                   st;
    frm_pkg::frm_rd_e                   next_st;
    logic [frm_pkg::IMG_WORDS_W-1:0]    cnt;
    logic [frm_pkg::IMG_W-1:0]          cur_slot;
    wire                                last_word = &cnt;
    wire                                got_word  = (st == frm_pkg::RD_WAIT) && flash_rd_valid;

    // Slot number forms the top address bits
    // four image slots
    assign flash_rd_addr = {cur_slot, cnt};
    assign flash_rd_req  = (st == frm_pkg::RD_REQ);

    always_comb
    begin
        next_st = st;
        case (st)
            frm_pkg::RD_IDLE: if (start) next_st = frm_pkg::RD_REQ;
            frm_pkg::RD_REQ:  next_st = frm_pkg::RD_WAIT;
            frm_pkg::RD_WAIT: if (got_word) next_st = last_word ? frm_pkg::RD_IDLE : frm_pkg::RD_REQ;
            default:          next_st = frm_pkg::RD_IDLE;
        endcase
        if (abort)
            next_st = frm_pkg::RD_IDLE;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st        <= frm_pkg::RD_IDLE;
            cnt       <= '0;
            cur_slot  <= '0;
            word_wr   <= 1'b0;
            word_data <= '0;
            done      <= 1'b0;
        end
        else
        begin
            st      <= next_st;
            word_wr <= got_word && !abort;
            done    <= got_word && last_word && !abort;
            if (got_word)
                word_data <= flash_rd_data;
            if (start && st == frm_pkg::RD_IDLE)
            begin
                cnt      <= '0;
                cur_slot <= slot;
            end
            else if (got_word)
                cnt <= cnt + 1'b1;
        end
    end
endmodule

// file: verilog/frm_reload_manager.sv
// Purpose: FPGA image load and reload manager that keeps the board visible to the host
// Assumes: Host config accesses and flash write ports run on mclk; switch, done
//          and JTAG-active levels are pins and are synchronised here
// Notes:   Config space answers and identity never depend on FPGA state; the status word reports it
`timescale 1ns/1ps
module frm_reload_manager
#(
    parameter int                 DONE_TMO_CYC = frm_pkg::DONE_TMO_CYC,
    parameter logic [15:0]        VENDOR_ID    = 16'h1AB5,   // Arbitrary value
    parameter logic [15:0]        DEVICE_ID    = 16'h0C3E    // Arbitrary value
)
(
    input  wire logic                           mclk,
    input  wire logic                           rstn,
    // Host configuration space
    input  wire logic                           cfg_rd,
    input  wire logic                           cfg_wr,
    input  wire logic [frm_pkg::CFG_ADDR_W-1:0] cfg_addr,
    input  wire logic [frm_pkg::DATA_W-1:0]     cfg_wdata,
    output logic                                cfg_rvalid,
    output logic      [frm_pkg::DATA_W-1:0]     cfg_rdata,
    // Host load control
    input  wire logic                           host_sel_valid,
    input  wire logic [frm_pkg::IMG_W-1:0]      host_sel_img,
    input  wire logic                           host_reload,
    input  wire logic                           host_strm_start,
    input  wire logic                           host_strm_valid,
    input  wire logic                           host_strm_last,
    input  wire logic [frm_pkg::DATA_W-1:0]     host_strm_data,
    output logic                                host_strm_ready,
    // Flash programming sources
    input  wire logic                           host_fw_valid,
    input  wire logic [frm_pkg::FADDR_W-1:0]    host_fw_addr,
    input  wire logic [frm_pkg::DATA_W-1:0]     host_fw_data,
    output logic                                host_fw_ready,
    input  wire logic                           jtag_fw_valid,
    input  wire logic [frm_pkg::FADDR_W-1:0]    jtag_fw_addr,
    input  wire logic [frm_pkg::DATA_W-1:0]     jtag_fw_data,
    output logic                                jtag_fw_ready,
    // Flash device
    output logic                                flash_rd_req,
    output logic      [frm_pkg::FADDR_W-1:0]    flash_rd_addr,
    input  wire logic                           flash_rd_valid,
    input  wire logic [frm_pkg::DATA_W-1:0]     flash_rd_data,
    output frm_pkg::frm_fwr_s                   flash_wr,
    // Pins
    input  wire logic [frm_pkg::IMG_W-1:0]      boot_sw,
    input  wire logic                           jtag_cfg_active,
    input  wire logic                           fpga_done,
    // FPGA configuration port and user side
    output frm_pkg::frm_fcfg_s                  fpga_cfg,
    output logic                                user_rst_n,
    input  wire logic                           usr_req,
    output logic                                usr_grant
);
    frm_pkg::frm_state_e            state;
    frm_pkg::frm_state_e            next_state;
    frm_pkg::frm_src_e              src;
    logic [31:0]                    tmr;
    logic [frm_pkg::IMG_W-1:0]      boot_img;
    logic [frm_pkg::IMG_W-1:0]      sel_img;
    logic [frm_pkg::IMG_W-1:0]      load_img;
    logic [frm_pkg::DATA_W-1:0]     cfg_cmd;
    logic [frm_pkg::IMG_W-1:0]      sw_s1;
    logic [frm_pkg::IMG_W-1:0]      sw_s2;
    logic                           done_s1;
    logic                           done_s2;
    logic                           jt_s1;
    logic                           jt_s2;
    logic                           jt_d;
    logic                           rd_wr;
    logic [frm_pkg::DATA_W-1:0]     rd_data;
    logic                           rd_done;

    wire        jtag_rise   = jt_s2 && !jt_d;
    wire        in_prog     = (state == frm_pkg::S_PROG);
    wire        prog_end    = in_prog && (tmr == 32'(frm_pkg::PROG_LOW_CYC - 1));
    wire        boot_end    = (state == frm_pkg::S_BOOT) && (tmr == 32'(frm_pkg::STRAP_SETTLE - 1));
    wire        wait_tmo    = (state == frm_pkg::S_WAIT) && (tmr == 32'(DONE_TMO_CYC - 1));
    wire        may_reload  = (state == frm_pkg::S_RUN) || (state == frm_pkg::S_FAIL);
    wire        start_flash = may_reload && host_reload && !jtag_rise;
    wire        start_strm  = may_reload && host_strm_start && !host_reload && !jtag_rise;
    wire        strm_take   = host_strm_valid && host_strm_ready;
    wire        configured  = (state == frm_pkg::S_RUN);
    wire        rd_start    = prog_end && (src == frm_pkg::SRC_FLASH);
    wire        rd_abort    = jtag_rise;

    assign host_strm_ready = (state == frm_pkg::S_STREAM);
    // JTAG first, host second; both refused while the flash is being read
    assign jtag_fw_ready   = (state != frm_pkg::S_FLASH);
    assign host_fw_ready   = (state != frm_pkg::S_FLASH) && !jtag_fw_valid;
    wire        jtag_fw_take = jtag_fw_valid && jtag_fw_ready;
    wire        host_fw_take = host_fw_valid && host_fw_ready;
    // host access only to configured logic
    assign usr_grant       = usr_req && configured;

    wire [frm_pkg::DATA_W-1:0] stat_word = {
        16'h0000,
        2'b00, boot_img,
        2'b00, sel_img,
        2'b00, load_img,
        1'b0, (state == frm_pkg::S_JTAG), (state == frm_pkg::S_FAIL), configured};

    // identity is a constant, unaffected by reloads
    wire [frm_pkg::DATA_W-1:0] cfg_mux =
        (cfg_addr == frm_pkg::CFG_ID)   ? {DEVICE_ID, VENDOR_ID} :
        (cfg_addr == frm_pkg::CFG_CMD)  ? cfg_cmd :
        (cfg_addr == frm_pkg::CFG_STAT) ? stat_word : 32'h00000000;

    frm_flash_reader u_reader
    (
        .mclk           (mclk),
        .rstn           (rstn),
        .start          (rd_start),
        .abort          (rd_abort),
        .slot           (load_img),
        .flash_rd_req   (flash_rd_req),
        .flash_rd_addr  (flash_rd_addr),
        .flash_rd_valid (flash_rd_valid),
        .flash_rd_data  (flash_rd_data),
        .word_wr        (rd_wr),
        .word_data      (rd_data),
        .done           (rd_done)
    );

    // Pin synchronisers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sw_s1   <= '0;
            sw_s2   <= '0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            jt_s1   <= 1'b0;
            jt_s2   <= 1'b0;
            jt_d    <= 1'b0;
        end
        else
        begin
            sw_s1   <= boot_sw;
            sw_s2   <= sw_s1;
            done_s1 <= fpga_done;
            done_s2 <= done_s1;
            jt_s1   <= jtag_cfg_active;
            jt_s2   <= jt_s1;
            jt_d    <= jt_s2;
        end
    end

    always_comb
    begin
        next_state = state;
        case (state)
            frm_pkg::S_BOOT:   if (boot_end) next_state = frm_pkg::S_PROG;
            frm_pkg::S_PROG:   if (prog_end)
                                   next_state = (src == frm_pkg::SRC_FLASH) ? frm_pkg::S_FLASH : frm_pkg::S_STREAM;
            frm_pkg::S_FLASH:  if (rd_done) next_state = frm_pkg::S_WAIT;
            frm_pkg::S_STREAM: if (strm_take && host_strm_last) next_state = frm_pkg::S_WAIT;
            frm_pkg::S_WAIT:
                if (done_s2)
                    next_state = frm_pkg::S_RUN;
                else if (wait_tmo)
                    next_state = frm_pkg::S_FAIL;
            frm_pkg::S_RUN:
                if (start_flash || start_strm)
                    next_state = frm_pkg::S_PROG;
                else if (!done_s2)
                    next_state = frm_pkg::S_FAIL;
            frm_pkg::S_FAIL:   if (start_flash || start_strm) next_state = frm_pkg::S_PROG;
            // FPGA left to JTAG; check done once it lets go
            frm_pkg::S_JTAG:   if (!jt_s2) next_state = frm_pkg::S_WAIT;
            default:           next_state = frm_pkg::S_BOOT;
        endcase
        // JTAG direct load overrides any other path in every state except S_BOOT
        if (jtag_rise && state != frm_pkg::S_BOOT)
            next_state = frm_pkg::S_JTAG;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state    <= frm_pkg::S_BOOT;
            src      <= frm_pkg::SRC_FLASH;
            tmr      <= '0;
            boot_img <= '0;
            sel_img  <= '0;
            load_img <= '0;
        end
        else
        begin
            state <= next_state;
            tmr   <= (next_state != state) ? 32'h00000000 : tmr + 32'h00000001;
            // boot switch caught after it has settled
            if (boot_end)
            begin
                boot_img <= sw_s2;
                sel_img  <= sw_s2;
                load_img <= sw_s2;
                src      <= frm_pkg::SRC_FLASH;
            end
            // reload loads the previous selection; a selection in the same cycle comes too late
            if (host_sel_valid)
                sel_img <= host_sel_img;
            if (start_flash)
            begin
                load_img <= sel_img;
                src      <= frm_pkg::SRC_FLASH;
            end
            else if (start_strm)
                src <= frm_pkg::SRC_STREAM;
        end
    end

    // FPGA configuration port and user reset
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fpga_cfg   <= '{prog_n: 1'b0, wr: 1'b0, data: '0};
            user_rst_n <= 1'b0;
        end
        else
        begin
            fpga_cfg.prog_n <= !(next_state == frm_pkg::S_PROG);
            // stream words go straight to the FPGA
            fpga_cfg.wr     <= (state == frm_pkg::S_STREAM) ? strm_take : (rd_wr && state == frm_pkg::S_FLASH);
            if (strm_take)
                fpga_cfg.data <= host_strm_data;
            else if (rd_wr)
                fpga_cfg.data <= rd_data;
            // user logic in reset until done
            user_rst_n      <= (next_state == frm_pkg::S_RUN);
        end
    end

    // Flash writes and host config space
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            flash_wr   <= '{wr: 1'b0, addr: '0, data: '0};
            cfg_rvalid <= 1'b0;
            cfg_rdata  <= '0;
            cfg_cmd    <= frm_pkg::CMD_RST;
        end
        else
        begin
            // only the programming ports reach the flash
            flash_wr.wr <= jtag_fw_take || host_fw_take;
            if (jtag_fw_take)
            begin
                flash_wr.addr <= jtag_fw_addr;
                flash_wr.data <= jtag_fw_data;
            end
            else if (host_fw_take)
            begin
                flash_wr.addr <= host_fw_addr;
                flash_wr.data <= host_fw_data;
            end
            // answered from reset in every state
            cfg_rvalid <= cfg_rd;
            if (cfg_rd)
                cfg_rdata <= cfg_mux;
            // kept across reloads; only the host changes it
            if (cfg_wr && cfg_addr == frm_pkg::CFG_CMD)
                cfg_cmd <= cfg_wdata;
        end
    end

    property p_cfg_answer;
        @(posedge mclk) disable iff (!rstn) cfg_rd |=> cfg_rvalid;
    endproperty
    a_cfg_answer: assert property (p_cfg_answer) else $error("config read not answered");

    property p_flash_slot;
        @(posedge mclk) disable iff (!rstn)
            flash_rd_req |-> flash_rd_addr[frm_pkg::FADDR_W-1 -: frm_pkg::IMG_W] == load_img;
    endproperty
    a_flash_slot: assert property (p_flash_slot) else $error("flash read outside loaded slot");

    property p_host_fw;
        @(posedge mclk) disable iff (!rstn)
            host_fw_valid && host_fw_ready |=> flash_wr.wr && flash_wr.addr == $past(host_fw_addr);
    endproperty
    a_host_fw: assert property (p_host_fw) else $error("host flash write lost");

    property p_boot_img;
        @(posedge mclk) disable iff (!rstn)
            boot_end |=> load_img == $past(sw_s2) && state == frm_pkg::S_PROG;
    endproperty
    a_boot_img: assert property (p_boot_img) else $error("boot slot not from switch");

    property p_reload;
        @(posedge mclk) disable iff (!rstn)
            start_flash |=> state == frm_pkg::S_PROG && load_img == $past(sel_img) ##[1:60] !fpga_cfg.prog_n;
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not load selection");

    property p_strm_fwd;
        @(posedge mclk) disable iff (!rstn)
            strm_take |=> fpga_cfg.wr && fpga_cfg.data == $past(host_strm_data);
    endproperty
    a_strm_fwd: assert property (p_strm_fwd) else $error("stream word not forwarded");

    property p_strm_noflash;
        @(posedge mclk) disable iff (!rstn)
            state == frm_pkg::S_STREAM && !host_fw_valid && !jtag_fw_valid |=> !flash_wr.wr;
    endproperty
    a_strm_noflash: assert property (p_strm_noflash) else $error("stream reached flash");

    property p_jtag_quiet;
        @(posedge mclk) disable iff (!rstn)
            (state == frm_pkg::S_JTAG)[*2] |-> !fpga_cfg.wr && fpga_cfg.prog_n && !flash_rd_req;
    endproperty
    a_jtag_quiet: assert property (p_jtag_quiet) else $error("port driven during JTAG load");

    property p_cmd_keep;
        @(posedge mclk) disable iff (!rstn)
            !(cfg_wr && cfg_addr == frm_pkg::CFG_CMD) |=> $stable(cfg_cmd);
    endproperty
    a_cmd_keep: assert property (p_cmd_keep) else $error("config space changed by hardware");

    property p_id;
        @(posedge mclk) disable iff (!rstn)
            cfg_rd && cfg_addr == frm_pkg::CFG_ID |=> cfg_rdata == {DEVICE_ID, VENDOR_ID};
    endproperty
    a_id: assert property (p_id) else $error("identity changed");

    property p_user_hold;
        @(posedge mclk) disable iff (!rstn)
            !configured |-> !usr_grant ##1 (user_rst_n == (state == frm_pkg::S_RUN));
    endproperty
    a_user_hold: assert property (p_user_hold) else $error("user logic exposed unconfigured");

    c_run:    cover property (@(posedge mclk) disable iff (!rstn) $rose(configured));
    c_reload: cover property (@(posedge mclk) disable iff (!rstn) start_flash);
    c_stream: cover property (@(posedge mclk) disable iff (!rstn) strm_take && host_strm_last);
    c_jtag:   cover property (@(posedge mclk) disable iff (!rstn) state == frm_pkg::S_JTAG);
endmodule
